// File: bench/drs_board.sv
// drs_board.sv: board reset source, strap drivers and pci host model
module drs_board (
	input  wire logic aclk,
	output logic      reset_in_n,
	output logic      host_warm_reset,
	output logic      pci_reset_in,
	output logic [3:0] emif_address_bus_strap,
	output logic      endian_select_strap,
	output logic      pci_eeprom_autoinit_strap,
	output logic      host_data_bit5_strap,
	output logic      pci_enable_strap,
	output logic      serial_port2_enable_strap
);
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 1'b0;
	int   pclk_n = 0;

	// ----------------------------------------------------------------
	// pci clock and board drive
	// ----------------------------------------------------------------
	always #15 pclk = ~pclk;
	always @(posedge pclk) if (pclk_n < 64) pclk_n++;

	initial begin
		reset_in_n = 1'b0;
		host_warm_reset = 1'b0;
		pci_reset_in = 1'b0;
		{emif_address_bus_strap, endian_select_strap, pci_eeprom_autoinit_strap} = 6'h0;
		{host_data_bit5_strap, pci_enable_strap, serial_port2_enable_strap} = 3'h0;
	end

	// s = {addr[3:0], endian, autoinit, data5, pci enable, serial port 2 enable}
	task automatic hw_reset(input int n, input logic [8:0] s);
		@(posedge aclk);
		reset_in_n <= 1'b0;
		@(posedge aclk);
		{emif_address_bus_strap, endian_select_strap, pci_eeprom_autoinit_strap} <= s[8:3];
		{host_data_bit5_strap, pci_enable_strap, serial_port2_enable_strap} <= s[2:0];
		repeat (n) @(posedge aclk);
		while (pclk_n < 32) @(posedge aclk);
		reset_in_n <= 1'b1;
	endtask : hw_reset

	task automatic set_straps(input logic [8:0] s);
		@(posedge aclk);
		{emif_address_bus_strap, endian_select_strap, pci_eeprom_autoinit_strap} <= s[8:3];
		{host_data_bit5_strap, serial_port2_enable_strap} <= {s[2], s[0]};
	endtask : set_straps

	task automatic warm;
		@(posedge aclk);
		host_warm_reset <= 1'b1;
		@(posedge aclk);
		host_warm_reset <= 1'b0;
	endtask : warm

	task automatic pci_rst(input int n);
		@(posedge aclk);
		pci_reset_in <= 1'b1;
		repeat (n) @(posedge aclk);
		pci_reset_in <= 1'b0;
	endtask : pci_rst
endmodule : drs_board

// File: bench/drs_top_asserts.sv
// drs_top_asserts.sv: port checker for the reset sequencer
module drs_chk (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       reset_in_n,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_bvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       host_warm_reset,
	input wire logic       pci_reset_in,
	input wire logic       pci_enable_strap,
	input wire logic       serial_port2_enable_strap,
	input wire logic       core_reset_n,
	input wire logic       pci_sm_reset_n,
	input wire logic [7:0] boot_cfg,
	input wire logic       emif_clk_resync,
	input wire logic       emif_output_clock1_oe,
	input wire logic       emif_bus_oe,
	input wire logic       hold_acknowledge_oe,
	input wire logic       bus_request_oe,
	input wire logic       eeprom_chip_select_oe,
	input wire logic       eeprom_serial_clock_oe,
	input wire logic       eeprom_serial_out_oe,
	input wire logic       zgroup_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_pci_isolate: assert property ($past(aresetn) |-> pci_sm_reset_n == !$past(pci_reset_in))
		else $error("pci state reset not following its own input");
	a_zgrp_fall: assert property ($fell(core_reset_n) |-> !zgroup_oe && !eeprom_chip_select_oe)
		else $error("z group or eeprom select still driven at reset");
	a_zgrp_rise: assert property ($rose(core_reset_n) |-> !zgroup_oe [*4] ##1 zgroup_oe)
		else $error("z group release off its window");
	a_eeprom_early: assert property ($rose(core_reset_n) && pci_enable_strap
		&& !serial_port2_enable_strap |-> ##4 (eeprom_chip_select_oe && eeprom_serial_clock_oe
		&& eeprom_serial_out_oe))
		else $error("eeprom pins late after release");
	a_emif_float: assert property ($fell(core_reset_n) && emif_bus_oe |-> emif_bus_oe [*8] ##1
		!(emif_bus_oe || bus_request_oe || hold_acknowledge_oe || emif_output_clock1_oe))
		else $error("memory groups float off their window");
	a_emif_valid: assert property ($rose(core_reset_n) |-> ##64 ($rose(emif_bus_oe)
		&& bus_request_oe && hold_acknowledge_oe && emif_output_clock1_oe))
		else $error("memory groups valid off their window");
	a_resync_fall: assert property ($fell(core_reset_n) |-> ##8 emif_clk_resync)
		else $error("no clock resync after reset fall");
	a_resync_rise: assert property ($rose(core_reset_n) |-> ##8 emif_clk_resync)
		else $error("no clock resync after reset rise");
	a_boot_keep: assert property ($past(reset_in_n, 3) |-> $stable(boot_cfg))
		else $error("boot config moved while running");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not returned next cycle");

	c_emif_up: cover property ($rose(emif_bus_oe));
	c_warm: cover property (host_warm_reset && core_reset_n);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : drs_chk

bind drs_top drs_chk i_chk (.aclk, .aresetn, .reset_in_n, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid,
	.s_axi_bvalid, .s_axi_bresp, .host_warm_reset, .pci_reset_in, .pci_enable_strap,
	.serial_port2_enable_strap, .core_reset_n, .pci_sm_reset_n, .boot_cfg, .emif_clk_resync,
	.emif_output_clock1_oe, .emif_bus_oe, .hold_acknowledge_oe, .bus_request_oe,
	.eeprom_chip_select_oe, .eeprom_serial_clock_oe, .eeprom_serial_out_oe, .zgroup_oe);

// File: bench/tb_top.sv
// tb_top.sv: self-checking bench for the reset sequencer
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import drs_pkg::*;
	typedef struct packed {logic [8:0] s; logic [7:0] boot;} drs_row_t;
	logic aclk = 1'b0, aresetn = 1'b0, hold_request_in = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, boot_cfg;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf, emif_address_bus_strap;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic reset_in_n, host_warm_reset, pci_reset_in, endian_select_strap;
	logic pci_eeprom_autoinit_strap, host_data_bit5_strap, pci_enable_strap;
	logic serial_port2_enable_strap, core_reset_n, pci_sm_reset_n, emif_clk_resync;
	logic emif_output_clock1_oe, emif_bus_oe, hold_acknowledge_oe, bus_request_oe;
	logic eeprom_chip_select_oe, eeprom_serial_clock_oe, eeprom_serial_out_oe, zgroup_oe;
	int n_fail = 0, total_checks = 0;
	drs_row_t rows [3] = '{'{9'h0b4, 8'ha5}, '{9'h14b, 8'h4a}, '{9'h07e, 8'he3}};

	drs_top #(.RST_MIN_CYC(20)) i_dut (.*);
	drs_board i_board (.*);

	always #25 aclk = ~aclk;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic to_fail;
		n_fail++;
		$display("MISMATCH t=%0t wait ran out", $time);
		test_done;
	endtask : to_fail

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		int i;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		rs = 2'h3;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				rs = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (i == 50) to_fail;
	endtask : axi_wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int i;
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (i == 50) to_fail;
		s_axi_rready <= 1'b0;
		chk({30'h0, s_axi_rresp}, {30'h0, er}, "read resp");
		chk(s_axi_rdata, e, "read data");
	endtask : rd_chk

	task automatic settle;
		int i;
		for (i = 0; i < 40 && core_reset_n !== 1'b0; i++) @(posedge aclk);
		if (i == 40) to_fail;
		for (i = 0; i < 300 && core_reset_n !== 1'b1; i++) @(posedge aclk);
		if (i == 300) to_fail;
		for (i = 0; i < 300 && emif_bus_oe !== 1'b1; i++) @(posedge aclk);
		if (i == 300) to_fail;
		@(posedge aclk);
	endtask : settle

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		#2000000;
		to_fail;
	end

	initial begin
		repeat (2) @(posedge aclk);
		#1;
		chk({core_reset_n, s_axi_awready, s_axi_bvalid, boot_cfg}, 11'h200, "reset values");
		@(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[k]) begin
			i_board.hw_reset(25, rows[k].s);
			#1;
			chk(pci_sm_reset_n, 1, "pci sm during hw reset");
			settle;
			chk(boot_cfg, rows[k].boot, "boot cfg");
			rd_chk(STATUS_OFF, {18'h0, 2'h1, 2'h0, rows[k].s[0], rows[k].s[1], rows[k].boot}, RESP_OKAY);
			$display("row %0d done", k);
		end
		hold_request_in <= 1'b1;
		i_board.hw_reset(3, 9'h07e);
		settle;
		rd_chk(STATUS_OFF, {18'h0, 2'h1, 1'b1, 3'h1, 8'he3}, RESP_OKAY);
		axi_wr(CTRL_OFF, 32'h2, r);
		rd_chk(STATUS_OFF, {18'h0, 2'h1, 1'b0, 3'h1, 8'he3}, RESP_OKAY);
		$display("short pulse done");
		i_board.set_straps(9'h000);
		i_board.warm();
		settle;
		chk(boot_cfg, 8'he3, "boot after warm");
		rd_chk(STATUS_OFF, {18'h0, 2'h2, 1'b0, 3'h1, 8'he3}, RESP_OKAY);
		$display("warm reset done");
		axi_wr(CTRL_OFF, 32'h1, r);
		chk(r, RESP_OKAY, "ctrl write");
		settle;
		chk(boot_cfg, 8'he3, "boot after emulation");
		rd_chk(STATUS_OFF, {18'h0, 2'h3, 1'b0, 3'h1, 8'he3}, RESP_OKAY);
		$display("emulation reset done");
		i_board.pci_rst(4);
		#1;
		chk({pci_sm_reset_n, core_reset_n, emif_bus_oe}, 3'h3, "pci reset alone");
		repeat (2) @(posedge aclk);
		#1;
		chk(pci_sm_reset_n, 1, "pci reset released");
		$display("pci reset done");
		rd_chk(8'h10, 32'h0, RESP_SLVERR);
		axi_wr(8'h10, 32'h1, r);
		chk(r, RESP_SLVERR, "unmapped write");
		axi_wr(STATUS_OFF, 32'hffffffff, r);
		chk(r, RESP_OKAY, "status write");
		rd_chk(STATUS_OFF, {18'h0, 2'h3, 1'b0, 3'h1, 8'he3}, RESP_OKAY);
		$display("register map done");
		test_done;
	end
endmodule : tb_top

// File: src/drs_pkg.sv
// drs_pkg.sv: constants and types for the device reset sequencer
package drs_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 50;
	localparam int EMIF_RATIO      = 4;
	localparam int P_NS            = CLK_PERIOD_NS;
	localparam int E_NS            = EMIF_RATIO * P_NS;
	localparam int T_RST_MIN_NS    = 250000;
	localparam int RST_MIN_CYC_DEF = T_RST_MIN_NS / CLK_PERIOD_NS;

	localparam int T_FALL_EMIF_NS  = 2 * E_NS;
	localparam int T_FALL_SYNC_NS  = 2 * E_NS;
	localparam int T_FALL_PIN_NS   = 0;
	localparam int T_RISE_SYNC_NS  = 2 * E_NS;
	localparam int T_RISE_EMIF_NS  = 16 * E_NS;
	localparam int T_RISE_LOW_NS   = 4 * P_NS;
	localparam int T_RISE_ZGRP_NS  = 4 * P_NS;

	localparam int PH_W            = 8;
	localparam int PULSE_W         = 13;

	function automatic logic [PH_W-1:0] drs_cyc_up(input int ns);
		drs_cyc_up = PH_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	endfunction : drs_cyc_up

	localparam logic [PH_W-1:0] FALL_EMIF_CYC = drs_cyc_up(T_FALL_EMIF_NS);
	localparam logic [PH_W-1:0] FALL_SYNC_CYC = drs_cyc_up(T_FALL_SYNC_NS);
	localparam logic [PH_W-1:0] FALL_PIN_CYC  = drs_cyc_up(T_FALL_PIN_NS);
	localparam logic [PH_W-1:0] RISE_SYNC_CYC = drs_cyc_up(T_RISE_SYNC_NS);
	localparam logic [PH_W-1:0] RISE_EMIF_CYC = drs_cyc_up(T_RISE_EMIF_NS);
	localparam logic [PH_W-1:0] RISE_LOW_CYC  = drs_cyc_up(T_RISE_LOW_NS);
	localparam logic [PH_W-1:0] RISE_ZGRP_CYC = drs_cyc_up(T_RISE_ZGRP_NS);

	localparam logic [4:0]      WARM_HOLD_CYC = 5'h10;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int          AXI_AW       = 8;
	localparam logic [7:0]  CTRL_OFF     = 8'h00;
	localparam logic [7:0]  STATUS_OFF   = 8'h04;
	localparam int          CTRL_EMU_BIT = 0;
	localparam int          CTRL_CLR_BIT = 1;
	localparam int          ST_PCI_BIT   = 8;
	localparam int          ST_SP2_BIT   = 9;
	localparam int          ST_INRST_BIT = 10;
	localparam int          ST_SHORT_BIT = 11;
	localparam int          ST_CAUSE_LSB = 12;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	localparam logic [7:0]  BOOT_RST     = 8'h00;

	typedef enum logic [1:0] {
		CAUSE_NONE,
		CAUSE_HW,
		CAUSE_WARM,
		CAUSE_EMU
	} drs_cause_t;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_FALL,
		ST_RISE
	} drs_state_t;

endpackage : drs_pkg

// File: src/drs_sync.sv
// drs_sync.sv: two-flop synchroniser for the hardware reset input
module drs_sync (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic d_in,
	output logic      q_out
);
	logic meta_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= 1'b0;
			q_out  <= 1'b0;
		end else begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end

endmodule : drs_sync

// File: src/drs_timer.sv
// drs_timer.sv: saturating cycle counter with synchronous clear
module drs_timer #(
	parameter int W = 8
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         clr,
	output logic [W-1:0]      cnt
);
	always_ff @(posedge aclk) begin
		if (!aresetn || clr) begin
			cnt <= '0;
		end else if (cnt != {W{1'b1}}) begin
			cnt <= cnt + W'(1);
		end
	end

endmodule : drs_timer

// File: src/drs_top.sv
// drs_top.sv: reset sequencer with strap capture and axi4-lite registers
module drs_top #(
	parameter int RST_MIN_CYC = drs_pkg::RST_MIN_CYC_DEF
) (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [drs_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [drs_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic                      reset_in_n,
	input  wire logic                      host_warm_reset,
	input  wire logic                      pci_reset_in,
	input  wire logic [3:0]                emif_address_bus_strap,
	input  wire logic                      endian_select_strap,
	input  wire logic                      pci_eeprom_autoinit_strap,
	input  wire logic                      host_data_bit5_strap,
	input  wire logic                      pci_enable_strap,
	input  wire logic                      serial_port2_enable_strap,
	input  wire logic                      hold_request_in,
	output logic                           core_reset_n,
	output logic                           pci_sm_reset_n,
	output logic [7:0]                     boot_cfg,
	output logic                           emif_clk_resync,
	output logic                           emif_output_clock1_oe,
	output logic                           emif_bus_oe,
	output logic                           hold_acknowledge_oe,
	output logic                           bus_request_oe,
	output logic                           eeprom_chip_select_oe,
	output logic                           eeprom_serial_clock_oe,
	output logic                           eeprom_serial_out_oe,
	output logic                           zgroup_oe
);
	import drs_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic                hw_n_sync;
	logic                hw_n_q_r;
	logic [PH_W-1:0]     ph_cnt;
	logic [PULSE_W-1:0]  pulse_cnt;
	drs_state_t          st_r;
	drs_state_t          st_nxt;
	logic [4:0]          warm_cnt_r;
	logic                warm_req;
	logic                rst_active;
	logic                pci_en_cap_r;
	logic                sp2_cap_r;
	logic                eeprom_early;
	drs_cause_t          cause_r;
	logic                emu_req_r;
	logic                short_flag_r;
	logic                short_set;
	logic                aw_got_r;
	logic                w_got_r;
	logic [AXI_AW-1:0]   awaddr_q_r;
	logic [31:0]         wdata_q_r;
	logic [3:0]          wstrb_q_r;
	logic                wr_fire;
	logic                wr_ctrl;
	logic [31:0]         status_word;

	// ----------------------------------------------------------------
	// group enable helper
	// ----------------------------------------------------------------
	function automatic logic grp_nxt(
		input logic            cur,
		input drs_state_t      st,
		input logic [PH_W-1:0] cnt,
		input logic [PH_W-1:0] fall_cyc,
		input logic [PH_W-1:0] rise_cyc
	);
		if (cur) begin
			grp_nxt = !(st == ST_FALL && cnt >= fall_cyc);
		end else begin
			grp_nxt = (st == ST_RUN) || (st == ST_RISE && cnt >= rise_cyc);
		end
	endfunction : grp_nxt

	// ----------------------------------------------------------------
	// reset input synchronisation and pulse width check
	// ----------------------------------------------------------------
	drs_sync u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d_in    (reset_in_n),
		.q_out   (hw_n_sync)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hw_n_q_r <= 1'b0;
		end else begin
			hw_n_q_r <= hw_n_sync;
		end
	end

	drs_timer #(.W(PULSE_W)) u_pulse (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (hw_n_sync),
		.cnt     (pulse_cnt)
	);

	// a release after a too short low pulse is flagged for software
	assign short_set = hw_n_sync && !hw_n_q_r &&
		(32'(pulse_cnt) < 32'(RST_MIN_CYC));

	// ----------------------------------------------------------------
	// strap capture, only while the hardware reset is low
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot_cfg     <= BOOT_RST;
			pci_en_cap_r <= 1'b0;
			sp2_cap_r    <= 1'b0;
		end else if (!hw_n_sync) begin
			boot_cfg     <= {host_data_bit5_strap, pci_eeprom_autoinit_strap,
				endian_select_strap, 1'b0, emif_address_bus_strap};
			pci_en_cap_r <= pci_enable_strap;
			sp2_cap_r    <= serial_port2_enable_strap;
		end
	end
	// warm and emulation resets leave the captured values alone

	assign eeprom_early = pci_en_cap_r && !sp2_cap_r;

	// ----------------------------------------------------------------
	// warm and emulation reset
	// ----------------------------------------------------------------
	assign warm_req = (host_warm_reset && pci_en_cap_r) || emu_req_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			warm_cnt_r <= 5'h00;
		end else if (warm_req) begin
			warm_cnt_r <= WARM_HOLD_CYC;
		end else if (warm_cnt_r != 5'h00) begin
			warm_cnt_r <= warm_cnt_r - 5'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cause_r <= CAUSE_NONE;
		end else if (!hw_n_sync) begin
			cause_r <= CAUSE_HW;
		end else if (emu_req_r) begin
			cause_r <= CAUSE_EMU;
		end else if (warm_req) begin
			cause_r <= CAUSE_WARM;
		end
	end

	assign rst_active = !hw_n_sync || (warm_cnt_r != 5'h00);

	// ----------------------------------------------------------------
	// sequencer state machine
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_RUN: begin
				if (rst_active) st_nxt = ST_FALL;
			end
			ST_FALL: begin
				// a cut pulse still runs the fall sequence to its end
				if (!rst_active && ph_cnt >= FALL_EMIF_CYC) st_nxt = ST_RISE;
			end
			ST_RISE: begin
				if (rst_active) st_nxt = ST_FALL;
				else if (ph_cnt >= RISE_EMIF_CYC) st_nxt = ST_RUN;
			end
			default: st_nxt = ST_FALL;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= ST_FALL;
		end else begin
			st_r <= st_nxt;
		end
	end

	drs_timer #(.W(PH_W)) u_phase (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (st_nxt != st_r),
		.cnt     (ph_cnt)
	);

	// ----------------------------------------------------------------
	// core and pci resets
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_reset_n <= 1'b0;
		end else begin
			core_reset_n <= (st_r != ST_FALL);
		end
	end

	// pci machine reset follows its own input only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pci_sm_reset_n <= 1'b0;
		end else begin
			pci_sm_reset_n <= !pci_reset_in;
		end
	end

	// ----------------------------------------------------------------
	// pin group enables
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			emif_clk_resync <= 1'b0;
		end else begin
			emif_clk_resync <= (st_r == ST_FALL && ph_cnt == FALL_SYNC_CYC) ||
				(st_r == ST_RISE && ph_cnt == RISE_SYNC_CYC);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			emif_output_clock1_oe <= 1'b0;
			emif_bus_oe           <= 1'b0;
		end else begin
			emif_output_clock1_oe <= grp_nxt(emif_output_clock1_oe, st_r, ph_cnt,
				FALL_EMIF_CYC, RISE_EMIF_CYC);
			emif_bus_oe           <= grp_nxt(emif_bus_oe, st_r, ph_cnt,
				FALL_EMIF_CYC, RISE_EMIF_CYC);
		end
	end

	// hold acknowledge follows the emif group timing whichever the hold request, as both branches are the same
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_acknowledge_oe <= 1'b0;
			bus_request_oe      <= 1'b0;
		end else begin
			if (hold_request_in) begin
				hold_acknowledge_oe <= grp_nxt(hold_acknowledge_oe, st_r, ph_cnt,
					FALL_EMIF_CYC, RISE_EMIF_CYC);
			end else begin
				hold_acknowledge_oe <= grp_nxt(hold_acknowledge_oe, st_r, ph_cnt,
					FALL_EMIF_CYC, RISE_EMIF_CYC);
			end
			bus_request_oe <= grp_nxt(bus_request_oe, st_r, ph_cnt,
				FALL_EMIF_CYC, RISE_EMIF_CYC);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eeprom_chip_select_oe  <= 1'b0;
			eeprom_serial_clock_oe <= 1'b0;
			eeprom_serial_out_oe   <= 1'b0;
			zgroup_oe              <= 1'b0;
		end else begin
			eeprom_chip_select_oe <= grp_nxt(eeprom_chip_select_oe, st_r, ph_cnt,
				FALL_PIN_CYC, RISE_LOW_CYC);
			if (eeprom_early) begin
				eeprom_serial_clock_oe <= grp_nxt(eeprom_serial_clock_oe, st_r, ph_cnt,
					FALL_PIN_CYC, RISE_LOW_CYC);
				eeprom_serial_out_oe   <= grp_nxt(eeprom_serial_out_oe, st_r, ph_cnt,
					FALL_PIN_CYC, RISE_LOW_CYC);
			end else begin
				eeprom_serial_clock_oe <= grp_nxt(eeprom_serial_clock_oe, st_r, ph_cnt,
					FALL_PIN_CYC, RISE_ZGRP_CYC);
				eeprom_serial_out_oe   <= grp_nxt(eeprom_serial_out_oe, st_r, ph_cnt,
					FALL_PIN_CYC, RISE_ZGRP_CYC);
			end
			zgroup_oe <= grp_nxt(zgroup_oe, st_r, ph_cnt,
				FALL_PIN_CYC, RISE_ZGRP_CYC);
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
	assign wr_ctrl = wr_fire && (awaddr_q_r == CTRL_OFF) && wstrb_q_r[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_got_r      <= 1'b0;
			w_got_r       <= 1'b0;
			awaddr_q_r    <= '0;
			wdata_q_r     <= 32'h0000_0000;
			wstrb_q_r     <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r      <= 1'b1;
				awaddr_q_r    <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r      <= 1'b1;
				wdata_q_r    <= s_axi_wdata;
				wstrb_q_r    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_got_r     <= 1'b0;
				w_got_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q_r == CTRL_OFF || awaddr_q_r == STATUS_OFF) ?
					RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// control register effects: emulation reset pulse, short flag clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			emu_req_r    <= 1'b0;
			short_flag_r <= 1'b0;
		end else begin
			emu_req_r <= wr_ctrl && wdata_q_r[CTRL_EMU_BIT];
			if (short_set) begin
				short_flag_r <= 1'b1;
			end else if (wr_ctrl && wdata_q_r[CTRL_CLR_BIT]) begin
				short_flag_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	always_comb begin
		status_word                          = 32'h0000_0000;
		status_word[7:0]                     = boot_cfg;
		status_word[ST_PCI_BIT]              = pci_en_cap_r;
		status_word[ST_SP2_BIT]              = sp2_cap_r;
		status_word[ST_INRST_BIT]            = (st_r != ST_RUN);
		status_word[ST_SHORT_BIT]            = short_flag_r;
		status_word[ST_CAUSE_LSB+1:ST_CAUSE_LSB] = cause_r;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				if (s_axi_araddr == STATUS_OFF) begin
					s_axi_rdata <= status_word;
					s_axi_rresp <= RESP_OKAY;
				end else if (s_axi_araddr == CTRL_OFF) begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_OKAY;
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule : drs_top
